// file: hdl/cae_top.sv
`timescale 1ns/1ps
`default_nettype none
module cae_top import cae_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DFLT
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic smbalert_o,
    output logic smbalert_oe_o,
    input wire logic cv_timer_term_i,
    input wire logic taper_term_i,
    input wire logic charge_time_fault_i,
    input wire logic bat_missing_i,
    input wire logic bat_short_i,
    input wire logic ilim_reg_active_i,
    input wire logic thermal_reg_active_i,
    input wire logic vin_uvcl_active_i,
    input wire logic iin_limit_active_i,
    input wire logic constant_current_i,
    input wire logic constant_voltage_i
);
    typedef struct packed {
        cae_state_t st;
        cae_phase_t ph;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic ara;
        logic lost;
        logic mack;
        logic [7:0] cmd;
        logic [7:0] lo;
        logic [7:0] txb;
        logic [7:0] txh;
        logic [STATE_W-1:0] state_en;
        logic [STATUS_W-1:0] status_en;
        logic sda_o;
        logic sda_oe;
        logic alert_o;
        logic alert_oe;
        logic service;
    } cae_top_s_t;

    cae_top_s_t s_q;
    cae_top_s_t s_d;
    cae_link_if lnk();

    cae_line_sampler u_sampler (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .lnk(lnk.sampler)
    );

    cae_alert_latch u_latch (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .lnk(lnk.latch)
    );

    logic [STATE_W-1:0] state_cond;
    logic [STATUS_W-1:0] status_cond;

    always_comb begin
        state_cond = '0;
        state_cond[BIT_CV_TIMER] = cv_timer_term_i;
        state_cond[BIT_TAPER] = taper_term_i;
        state_cond[BIT_CHG_TIME] = charge_time_fault_i;
        state_cond[BIT_BAT_MISSING] = bat_missing_i;
        state_cond[BIT_BAT_SHORT] = bat_short_i;
        status_cond = '0;
        status_cond[BIT_ILIM] = ilim_reg_active_i;
        status_cond[BIT_THERMAL] = thermal_reg_active_i;
        status_cond[BIT_UVCL] = vin_uvcl_active_i;
        status_cond[BIT_IIN] = iin_limit_active_i;
        status_cond[BIT_CC] = constant_current_i;
        status_cond[BIT_CV] = constant_voltage_i;
    end

    assign lnk.cond = {status_cond, state_cond};
    assign lnk.enable = {s_q.status_en, s_q.state_en};
    assign lnk.service = s_q.service;

    // register readback, low byte then high byte
    function automatic logic [15:0] rd_word(input logic [7:0] cmd,
                                            input logic [STATE_W-1:0] st_en,
                                            input logic [STATUS_W-1:0] stat_en);
        logic [15:0] w;
        w = '0;
        if (cmd == CMD_STATE_EN) begin
            w[STATE_W-1:0] = st_en;
        end else if (cmd == CMD_STATUS_EN) begin
            w[STATUS_W-1:0] = stat_en;
        end
        return w;
    endfunction

    logic [15:0] rd_data;
    assign rd_data = rd_word(s_q.cmd, s_q.state_en, s_q.status_en);

    always_comb begin
        s_d = s_q;
        s_d.service = 1'b0;
        s_d.sda_o = 1'b0;
        s_d.alert_o = 1'b0;
        // alert line pulled low while any enabled event is pending
        s_d.alert_oe = |lnk.pending;
        if (lnk.start) begin
            s_d.st = ST_RX;
            s_d.ph = PH_ADDR;
            s_d.cnt = '0;
            s_d.sda_oe = 1'b0;
            s_d.lost = 1'b0;
        end else if (lnk.stop) begin
            s_d.st = ST_IDLE;
            s_d.sda_oe = 1'b0;
        end else begin
            case (s_q.st)
                ST_IDLE: begin
                    s_d.sda_oe = 1'b0;
                end
                ST_RX: begin
                    if (lnk.scl_rise) begin
                        s_d.sh = {s_q.sh[6:0], lnk.sda};
                        s_d.cnt = s_q.cnt + 4'h1;
                    end else if (lnk.scl_fall && s_q.cnt == BITS_PER_BYTE) begin
                        s_d.st = ST_ACK;
                        s_d.sda_oe = 1'b1;
                        case (s_q.ph)
                            PH_ADDR: begin
                                if (s_q.sh[7:1] == DEV_ADDR) begin
                                    s_d.rw = s_q.sh[0];
                                    s_d.ara = 1'b0;
                                end else if (s_q.sh[7:1] == ARA_ADDR && s_q.sh[0]
                                             && s_q.alert_oe) begin
                                    s_d.rw = 1'b1;
                                    s_d.ara = 1'b1;
                                end else begin
                                    s_d.st = ST_IDLE;
                                    s_d.sda_oe = 1'b0;
                                end
                            end
                            PH_CMD: begin
                                s_d.cmd = s_q.sh;
                            end
                            PH_LO: begin
                                s_d.lo = s_q.sh;
                            end
                            PH_HI: begin
                                if (s_q.cmd == CMD_STATE_EN) begin
                                    s_d.state_en = s_q.lo[STATE_W-1:0];
                                end else if (s_q.cmd == CMD_STATUS_EN) begin
                                    s_d.status_en = s_q.lo[STATUS_W-1:0];
                                end
                            end
                            default: begin
                                s_d.st = ST_IDLE;
                                s_d.sda_oe = 1'b0;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (lnk.scl_fall) begin
                        s_d.sda_oe = 1'b0;
                        s_d.cnt = '0;
                        if (s_q.ph == PH_ADDR && s_q.rw) begin
                            s_d.st = ST_TX;
                            s_d.txb = s_q.ara ? {DEV_ADDR, 1'b0} : rd_data[7:0];
                            s_d.txh = s_q.ara ? 8'h00 : rd_data[15:8];
                            s_d.sda_oe = s_q.ara ? ~DEV_ADDR[6] : ~rd_data[7];
                        end else if (s_q.ph == PH_HI) begin
                            s_d.st = ST_IDLE;
                        end else begin
                            s_d.st = ST_RX;
                            s_d.ph = cae_phase_t'(s_q.ph + 2'b01);
                        end
                    end
                end
                ST_TX: begin
                    if (lnk.scl_rise && s_q.ara && s_q.txb[7] && !lnk.sda) begin
                        // lost alert-response arbitration to a lower address
                        s_d.lost = 1'b1;
                        s_d.st = ST_IDLE;
                        s_d.sda_oe = 1'b0;
                    end else if (lnk.scl_fall) begin
                        s_d.cnt = s_q.cnt + 4'h1;
                        if (s_q.cnt + 4'h1 == BITS_PER_BYTE) begin
                            s_d.st = ST_MACK;
                            s_d.sda_oe = 1'b0;
                        end else begin
                            s_d.txb = {s_q.txb[6:0], 1'b0};
                            s_d.sda_oe = ~s_q.txb[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (lnk.scl_rise) begin
                        s_d.mack = ~lnk.sda;
                        if (s_q.ara) begin
                            // address sent cleanly: host has serviced the alert
                            s_d.service = ~s_q.lost;
                            s_d.st = ST_IDLE;
                        end
                    end else if (lnk.scl_fall) begin
                        if (s_q.mack) begin
                            s_d.st = ST_TX;
                            s_d.cnt = '0;
                            s_d.txb = s_q.txh;
                            s_d.txh = 8'h00;
                            s_d.sda_oe = ~s_q.txh[7];
                        end else begin
                            s_d.st = ST_IDLE;
                        end
                    end
                end
                default: begin
                    s_d.st = ST_IDLE;
                    s_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.ph <= PH_ADDR;
            s_q.state_en <= STATE_EN_RST;
            s_q.status_en <= STATUS_EN_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign sda_o = s_q.sda_o;
    assign sda_oe_o = s_q.sda_oe;
    assign smbalert_o = s_q.alert_o;
    assign smbalert_oe_o = s_q.alert_oe;
endmodule
`default_nettype wire

// file: hdl/cae_pkg.sv
package cae_pkg;
    localparam int STATE_W = 5;
    localparam int STATUS_W = 6;
    localparam int EVT_W = STATE_W + STATUS_W;
    localparam logic [7:0] CMD_STATE_EN = 8'h0e;
    localparam logic [7:0] CMD_STATUS_EN = 8'h0f;
    localparam logic [STATE_W-1:0] STATE_EN_RST = 5'h00;
    localparam logic [STATUS_W-1:0] STATUS_EN_RST = 6'h00;
    localparam int BIT_CV_TIMER = 4;
    localparam int BIT_TAPER = 3;
    localparam int BIT_CHG_TIME = 2;
    localparam int BIT_BAT_MISSING = 1;
    localparam int BIT_BAT_SHORT = 0;
    localparam int BIT_ILIM = 5;
    localparam int BIT_THERMAL = 4;
    localparam int BIT_UVCL = 3;
    localparam int BIT_IIN = 2;
    localparam int BIT_CC = 1;
    localparam int BIT_CV = 0;
    localparam logic [6:0] ARA_ADDR = 7'h0c;
    // arbitrary default bus address
    localparam logic [6:0] DEV_ADDR_DFLT = 7'h5a;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CMD = 2'b01,
        PH_LO = 2'b10,
        PH_HI = 2'b11
    } cae_phase_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_MACK = 3'b100
    } cae_state_t;
endpackage

// file: hdl/cae_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cae_link_if;
    import cae_pkg::*;
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic [EVT_W-1:0] cond;
    logic [EVT_W-1:0] enable;
    logic [EVT_W-1:0] pending;
    logic service;
    modport top(input start, stop, scl_rise, scl_fall, sda, pending,
                output cond, enable, service);
    modport sampler(output start, stop, scl_rise, scl_fall, sda);
    modport latch(input cond, enable, service, output pending);
endinterface
`default_nettype wire

// file: hdl/cae_line_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module cae_line_sampler import cae_pkg::*; (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    cae_link_if.sampler lnk
);
    typedef struct packed {
        logic scl_a;
        logic sda_a;
        logic scl_b;
        logic sda_b;
    } cae_smp_t;

    cae_smp_t s_q;
    cae_smp_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.scl_a = scl_i;
        s_d.sda_a = sda_i;
        s_d.scl_b = s_q.scl_a;
        s_d.sda_b = s_q.sda_a;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '{scl_a: 1'b1, sda_a: 1'b1, scl_b: 1'b1, sda_b: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    // sda falling or rising while scl stays high
    assign lnk.start = s_q.scl_a & s_q.scl_b & s_q.sda_b & ~s_q.sda_a;
    assign lnk.stop = s_q.scl_a & s_q.scl_b & ~s_q.sda_b & s_q.sda_a;
    assign lnk.scl_rise = s_q.scl_a & ~s_q.scl_b;
    assign lnk.scl_fall = ~s_q.scl_a & s_q.scl_b;
    assign lnk.sda = s_q.sda_a;
endmodule
`default_nettype wire

// file: hdl/cae_alert_latch.sv
`timescale 1ns/1ps
`default_nettype none
module cae_alert_latch import cae_pkg::*; (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    cae_link_if.latch lnk
);
    typedef struct packed {
        logic [EVT_W-1:0] cond;
        logic [EVT_W-1:0] pend;
    } cae_lat_t;

    cae_lat_t s_q;
    cae_lat_t s_d;
    wire logic [EVT_W-1:0] pend_nx;

    always_comb begin
        s_d = s_q;
        s_d.cond = lnk.cond;
        s_d.pend = pend_nx;
    end

    // per event: latch on entry if enabled, set beats service clear
    for (genvar i = 0; i < EVT_W; i++) begin : g_evt
        logic rise;
        assign rise = lnk.cond[i] & ~s_q.cond[i];
        assign pend_nx[i] = ((s_q.pend[i] & ~lnk.service) | rise) & lnk.enable[i];
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign lnk.pending = s_q.pend;
endmodule
`default_nettype wire

// file: dv/cae_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cae_top_asserts import cae_pkg::*; (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic smbalert_o,
    input wire logic smbalert_oe_o,
    input wire logic cv_timer_term_i,
    input wire logic taper_term_i,
    input wire logic charge_time_fault_i,
    input wire logic bat_missing_i,
    input wire logic bat_short_i,
    input wire logic ilim_reg_active_i,
    input wire logic thermal_reg_active_i,
    input wire logic vin_uvcl_active_i,
    input wire logic iin_limit_active_i,
    input wire logic constant_current_i,
    input wire logic constant_voltage_i
);
    logic [EVT_W-1:0] ev;
    logic [EVT_W-1:0] ev_q;
    logic scl_q;
    logic [4:0] fall_q;
    logic [4:0] rise_q;
    logic [5:0] idle_q;
    logic busy;
    assign ev = {ilim_reg_active_i, thermal_reg_active_i, vin_uvcl_active_i, iin_limit_active_i,
        constant_current_i, constant_voltage_i, cv_timer_term_i, taper_term_i,
        charge_time_fault_i, bat_missing_i, bat_short_i};
    assign busy = idle_q < 6'h28;
    // edge history of the bus clock and the event inputs
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            scl_q <= 1'b1;
            ev_q <= '0;
            fall_q <= '0;
            rise_q <= '0;
            idle_q <= 6'h3f;
        end else begin
            scl_q <= scl_i;
            ev_q <= ev;
            fall_q <= {fall_q[3:0], scl_q & ~scl_i};
            rise_q <= {rise_q[3:0], |(ev & ~ev_q)};
            if (scl_i != scl_q) begin
                idle_q <= '0;
            end else if (idle_q != 6'h3f) begin
                idle_q <= idle_q + 6'h01;
            end
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence quiet_s;
        !smbalert_oe_o && !busy && (ev == '0);
    endsequence
    sequence latched_s;
        smbalert_oe_o && !busy;
    endsequence
    alert_drive_a: assert property (!smbalert_o)
        else $error("alert value driven high");
    sda_drive_a: assert property (!sda_o)
        else $error("data value driven high");
    alert_cause_a: assert property ($rose(smbalert_oe_o) |-> |rise_q)
        else $error("alert rose with no event edge");
    alert_hold_a: assert property ($fell(smbalert_oe_o) |-> busy)
        else $error("alert dropped while bus idle");
    ack_edge_a: assert property ($changed(sda_oe_o) |-> |fall_q)
        else $error("data drive changed away from clock fall");
    bus_idle_a: assert property (!busy |-> !sda_oe_o)
        else $error("data line held on idle bus");
    alert_stay_a: assert property (latched_s |=> smbalert_oe_o)
        else $error("alert not held until serviced");
    no_spur_a: assert property (quiet_s [*5] |=> !smbalert_oe_o)
        else $error("alert raised without cause");
endmodule
bind cae_top cae_top_asserts u_asserts (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .smbalert_o(smbalert_o),
    .smbalert_oe_o(smbalert_oe_o), .cv_timer_term_i(cv_timer_term_i),
    .taper_term_i(taper_term_i), .charge_time_fault_i(charge_time_fault_i),
    .bat_missing_i(bat_missing_i), .bat_short_i(bat_short_i),
    .ilim_reg_active_i(ilim_reg_active_i), .thermal_reg_active_i(thermal_reg_active_i),
    .vin_uvcl_active_i(vin_uvcl_active_i), .iin_limit_active_i(iin_limit_active_i),
    .constant_current_i(constant_current_i), .constant_voltage_i(constant_voltage_i));
`default_nettype wire

// file: dv/cae_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cae_host_model import cae_pkg::*; (
    input wire logic clk_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output logic sda_o
);
    logic drv;
    // released line pulled up
    assign sda_o = drv & ~sda_oe_i;
    initial begin
        scl_o = 1'b1;
        drv = 1'b1;
    end
    task automatic ph();
        repeat (6) @(posedge clk_i);
    endtask
    task automatic bit_x(input logic v, output logic r);
        drv <= v;
        ph();
        scl_o <= 1'b1;
        ph();
        r = sda_o;
        scl_o <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q,
        output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
            q[i] = r;
        end
        bit_x(m, r);
        a = ~r;
    endtask
    task automatic start();
        drv <= 1'b1;
        ph();
        scl_o <= 1'b1;
        ph();
        drv <= 1'b0;
        ph();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        drv <= 1'b0;
        ph();
        scl_o <= 1'b1;
        ph();
        drv <= 1'b1;
        ph();
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start();
        xfer({DEV_ADDR_DFLT, 1'b0}, 1'b1, q, a0);
        xfer(c, 1'b1, q, a1);
        xfer(d[7:0], 1'b1, q, a2);
        xfer(d[15:8], 1'b1, q, a3);
        stop();
        ok = a0 & a1 & a2 & a3;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, x;
        start();
        xfer({DEV_ADDR_DFLT, 1'b0}, 1'b1, q, a0);
        xfer(c, 1'b1, q, a1);
        start();
        xfer({DEV_ADDR_DFLT, 1'b1}, 1'b1, q, a2);
        xfer(8'hff, 1'b0, d[7:0], x);
        xfer(8'hff, 1'b1, d[15:8], x);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic ara(output logic [7:0] q, output logic ok);
        logic x;
        start();
        xfer({ARA_ADDR, 1'b1}, 1'b1, q, ok);
        if (ok) begin
            xfer(8'hff, 1'b1, q, x);
        end
        stop();
    endtask
endmodule
`default_nettype wire

// file: dv/cae_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("FAIL %s expected %h seen %h", n, e, a); end end
module cae_top_tb_top import cae_pkg::*;;
    logic core_clk;
    logic resetn;
    logic scl;
    logic sda;
    logic sda_oe;
    logic alert_oe;
    logic [EVT_W-1:0] ev;
    logic [EVT_W-1:0] m;
    logic [15:0] rd;
    logic [7:0] b;
    logic ok;
    logic nack;
    // rival responder, lower address with ones where ours has zeros
    localparam logic [6:0] RIVAL_ADDR = 7'h25;
    int error_cnt;
    int total_checks;
    cae_top u_dut (.core_clk_i(core_clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(sda_oe), .smbalert_o(), .smbalert_oe_o(alert_oe),
        .cv_timer_term_i(ev[4]), .taper_term_i(ev[3]), .charge_time_fault_i(ev[2]),
        .bat_missing_i(ev[1]), .bat_short_i(ev[0]), .ilim_reg_active_i(ev[10]),
        .thermal_reg_active_i(ev[9]), .vin_uvcl_active_i(ev[8]), .iin_limit_active_i(ev[7]),
        .constant_current_i(ev[6]), .constant_voltage_i(ev[5]));
    cae_host_model u_host (.clk_i(core_clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic pulse(input logic [EVT_W-1:0] v);
        @(posedge core_clk);
        ev <= v;
        repeat (2) @(posedge core_clk);
        ev <= '0;
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic t_access();
        u_host.rd(CMD_STATE_EN, rd, ok);
        `CHK("state mask reset", 16'h0000, rd)
        u_host.rd(CMD_STATUS_EN, rd, ok);
        `CHK("status mask reset", 16'h0000, rd)
        u_host.rd(8'h20, rd, ok);
        `CHK("unmapped read", 16'h0000, rd)
        u_host.wr(8'h20, 16'h001f, ok);
        `CHK("unmapped write ack", 1'b1, ok)
        u_host.rd(CMD_STATE_EN, rd, ok);
        `CHK("unmapped write dropped", 16'h0000, rd)
        u_host.wr(CMD_STATUS_EN, 16'hff3f, ok);
        `CHK("write ack", 1'b1, ok)
        u_host.rd(CMD_STATUS_EN, rd, ok);
        `CHK("status mask rw", 16'h003f, rd)
        u_host.wr(CMD_STATE_EN, 16'h00ff, ok);
        u_host.rd(CMD_STATE_EN, rd, ok);
        `CHK("state mask rw", 16'h001f, rd)
        $display("done: register access");
    endtask
    task automatic t_masked();
        u_host.wr(CMD_STATE_EN, 16'h0000, ok);
        u_host.wr(CMD_STATUS_EN, 16'h0000, ok);
        pulse('1);
        `CHK("masked alert", 1'b0, alert_oe)
        u_host.ara(b, ok);
        `CHK("masked response ack", 1'b0, ok)
        $display("done: masked events");
    endtask
    task automatic t_events();
        for (int i = 0; i < EVT_W; i++) begin
            m = 11'h001 << i;
            u_host.wr(CMD_STATE_EN, {11'h000, m[4:0]}, ok);
            u_host.wr(CMD_STATUS_EN, {10'h000, m[10:5]}, ok);
            pulse(~m);
            `CHK("other events", 1'b0, alert_oe)
            pulse(m);
            `CHK("enabled event", 1'b1, alert_oe)
            repeat (40) @(posedge core_clk);
            `CHK("alert held", 1'b1, alert_oe)
            u_host.ara(b, ok);
            `CHK("response address", {DEV_ADDR_DFLT, 1'b0}, b)
            `CHK("alert serviced", 1'b0, alert_oe)
        end
        $display("done: event enables");
    endtask
    task automatic t_clear();
        u_host.wr(CMD_STATE_EN, 16'h0001, ok);
        pulse(11'h001);
        `CHK("short alert", 1'b1, alert_oe)
        u_host.wr(CMD_STATE_EN, 16'h0000, ok);
        `CHK("alert dropped", 1'b0, alert_oe)
        $display("done: enable clear");
    endtask
    task automatic t_arbit();
        u_host.wr(CMD_STATE_EN, 16'h0000, ok);
        u_host.wr(CMD_STATUS_EN, 16'h0020, ok);
        pulse(11'h400);
        `CHK("limit alert", 1'b1, alert_oe)
        u_host.start();
        u_host.xfer({ARA_ADDR, 1'b1}, 1'b1, b, ok);
        `CHK("response ack", 1'b1, ok)
        u_host.xfer({RIVAL_ADDR, 1'b0}, 1'b1, b, nack);
        u_host.stop();
        `CHK("rival address", {RIVAL_ADDR, 1'b0}, b)
        `CHK("alert kept", 1'b1, alert_oe)
        u_host.ara(b, ok);
        `CHK("late response", {DEV_ADDR_DFLT, 1'b0}, b)
        `CHK("late serviced", 1'b0, alert_oe)
        $display("done: response arbitration");
    endtask
    task automatic t_reset();
        u_host.wr(CMD_STATE_EN, 16'h0001, ok);
        pulse(11'h001);
        `CHK("alert before reset", 1'b1, alert_oe)
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK("alert after reset", 1'b0, alert_oe)
        u_host.rd(CMD_STATE_EN, rd, ok);
        `CHK("state mask after reset", 16'h0000, rd)
        u_host.rd(CMD_STATUS_EN, rd, ok);
        `CHK("status mask after reset", 16'h0000, rd)
        $display("done: mid-run reset");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        ev = '0;
        error_cnt = 0;
        total_checks = 0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_access();
        t_masked();
        t_events();
        t_clear();
        t_arbit();
        t_reset();
        results();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        error_cnt++;
        results();
    end
endmodule
`default_nettype wire
